//--- verilog/chgopt_ctrl.sv
// Charger option control register, charge current holding register and
// the write watchdog that zeroes charge current when the host goes quiet.
// Assumes an upstream I2C slave delivering one-cycle byte write strobes
// on clk_sys; pins arriving from the analog side are asynchronous.
//
// Function
// [RL1] The watchdog period field picks off, 5 s, 88 s or 175 s, default 175 s.
// [RL2] With the watchdog on and no current or voltage write in time, charge current is forced to zero.
// [RL3] After expiry the timer restarts on a current, voltage or period field write.
// [RL4] With auto-off set and the battery pin low, the input limit loop enable is cleared.
// [RL5] With the source-mode flag set, the adapter good output is high in source mode.
// [RL6] Low-power mode on battery only switches off regulator, hot alert, monitors, comparator and ADC.
// [RL7] In low-power mode the comparator and its hot alert profile may still run when enabled.
// [RL8] The host should not enable low-power mode with an adapter present.
// [RL9] Audible-band avoidance clamps minimum burst frequency near 25 kHz in both directions.
// [RL10] The switching rate bit picks 1200 kHz when clear and 800 kHz when set.
// [RL11] The weak gate drive bit disables strong high-side turn-on drive when set.
// [RL12] Sixteen-bit writes apply only when low byte precedes high byte in time.
`timescale 1ns/1ps
module chgopt_ctrl
  import chgopt_pkg::*;
#(
  parameter longint WDT_5S_CYC = CHGOPT_WDT_5S_CYC,
  parameter longint WDT_88S_CYC = CHGOPT_WDT_88S_CYC,
  parameter longint WDT_175S_CYC = CHGOPT_WDT_175S_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic battery_present_cell_pin,
  input wire logic adapter_present,
  input wire logic source_mode_active,
  input wire logic adapter_valid,
  input wire logic hot_alert_lowpower_enable,
  output logic adapter_good_output,
  output logic internal_regulator_output,
  output logic hot_alert_enable,
  output logic monitor_enable,
  output logic comparator_enable,
  output logic adc_available,
  output logic audible_band_avoid,
  output logic switching_rate_select,
  output logic weak_gate_drive_select,
  output logic input_limit_loop_enable,
  output logic [15:0] charge_current,
  output logic watchdog_expired
);
  import chgopt_pkg::*;

  typedef struct packed {
    logic [15:0] opt;
    logic [15:0] ichg;
    logic [7:0] opt_lsb;
    logic opt_lsb_ok;
    logic [7:0] ichg_lsb;
    logic ichg_lsb_ok;
    logic [7:0] vchg_lsb;
    logic vchg_lsb_ok;
    logic [CHGOPT_CNT_W-1:0] wdt_cnt;
    logic expired;
    logic [7:0] rd;
    logic adapter_ok;
  } chgopt_state_t;

  chgopt_state_t st_reg;
  chgopt_state_t st_next;
  logic [2:0] pins_sync;
  logic bat_pin_s;
  logic src_mode_s;
  logic adp_present_s;

  // Analog-side pins are asynchronous to clk_sys
  chgopt_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in({battery_present_cell_pin, source_mode_active,
      adapter_present}),
    .sync_out(pins_sync)
  );

  assign bat_pin_s = pins_sync[2];
  assign src_mode_s = pins_sync[1];
  assign adp_present_s = pins_sync[0];

  // Period lookup for the two-bit watchdog field
  function automatic logic [CHGOPT_CNT_W-1:0] chgopt_limit(
    input logic [1:0] sel
  );
    logic [CHGOPT_CNT_W-1:0] lim;
    lim = '0;
    unique case (sel)
      CHGOPT_WDT_OFF: lim = '0;
      CHGOPT_WDT_5S: lim = CHGOPT_CNT_W'(WDT_5S_CYC); // RL1
      CHGOPT_WDT_88S: lim = CHGOPT_CNT_W'(WDT_88S_CYC); // RL1
      CHGOPT_WDT_175S: lim = CHGOPT_CNT_W'(WDT_175S_CYC); // RL1
    endcase
    return lim;
  endfunction : chgopt_limit

  // Byte read mux; unmapped offsets read as zero
  function automatic logic [7:0] chgopt_read(
    input logic [7:0] addr,
    input logic [15:0] opt,
    input logic [15:0] ichg
  );
    logic [7:0] d;
    d = '0;
    if (addr == CHGOPT_OFS_LSB)
      d = opt[7:0];
    else if (addr == CHGOPT_OFS_MSB)
      d = opt[15:8];
    else if (addr == CHGOPT_OFS_ICHG_LSB)
      d = ichg[7:0];
    else if (addr == CHGOPT_OFS_ICHG_MSB)
      d = ichg[15:8];
    return d;
  endfunction : chgopt_read

  // Next-state logic for registers, pairing and watchdog
  always_comb
  begin
    logic [CHGOPT_CNT_W-1:0] limit;
    logic wdt_on;
    logic restart;
    logic late;
    limit = '0;
    wdt_on = 1'b0;
    restart = 1'b0;
    late = 1'b0;
    st_next = st_reg;
    limit = chgopt_limit(st_reg.opt[CHGOPT_B_WDT_HI:CHGOPT_B_WDT_LO]);
    wdt_on = (limit != '0);
    // A low byte still pending when the period runs out goes stale;
    // judging this only at the expiry edge keeps pairs written after
    // expiry acceptable, else nothing could ever restart the timer
    late = wdt_on && !st_reg.expired &&
      (st_reg.wdt_cnt >= limit - CHGOPT_CNT_W'(1)); // RL12
    if (late)
    begin
      st_next.opt_lsb_ok = 1'b0; // RL12
      st_next.ichg_lsb_ok = 1'b0; // RL12
      st_next.vchg_lsb_ok = 1'b0; // RL12
    end
    if (wr_stb)
    begin
      unique case (wr_addr)
        CHGOPT_OFS_LSB:
        begin
          st_next.opt_lsb = wr_data; // RL12
          st_next.opt_lsb_ok = 1'b1;
        end
        CHGOPT_OFS_MSB:
        begin
          // High byte alone, first or late, is dropped
          if (st_reg.opt_lsb_ok)
          begin
            st_next.opt = {wr_data, st_reg.opt_lsb}; // RL12
            if (wr_data[CHGOPT_B_WDT_HI-8:CHGOPT_B_WDT_LO-8] !=
              st_reg.opt[CHGOPT_B_WDT_HI:CHGOPT_B_WDT_LO] ||
              st_reg.expired)
              restart = 1'b1; // RL3
          end
          st_next.opt_lsb_ok = 1'b0;
        end
        CHGOPT_OFS_ICHG_LSB:
        begin
          st_next.ichg_lsb = wr_data;
          st_next.ichg_lsb_ok = 1'b1;
        end
        CHGOPT_OFS_ICHG_MSB:
        begin
          if (st_reg.ichg_lsb_ok)
          begin
            st_next.ichg = {wr_data, st_reg.ichg_lsb}; // RL12
            restart = 1'b1; // RL3
          end
          st_next.ichg_lsb_ok = 1'b0;
        end
        CHGOPT_OFS_VCHG_LSB:
        begin
          st_next.vchg_lsb = wr_data;
          st_next.vchg_lsb_ok = 1'b1;
        end
        CHGOPT_OFS_VCHG_MSB:
        begin
          // Voltage value lives elsewhere; only its timing matters here
          if (st_reg.vchg_lsb_ok)
            restart = 1'b1; // RL3
          st_next.vchg_lsb_ok = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    // Watchdog counting and expiry
    if (restart || !wdt_on)
    begin
      st_next.wdt_cnt = '0; // RL3
      st_next.expired = 1'b0; // RL3
    end
    else if (!st_reg.expired)
    begin
      if (st_reg.wdt_cnt >= limit - CHGOPT_CNT_W'(1))
      begin
        st_next.expired = 1'b1; // RL2
        st_next.ichg = CHGOPT_ICHG_RESET; // RL2
        st_next.wdt_cnt = limit;
      end
      else
        st_next.wdt_cnt = st_reg.wdt_cnt + CHGOPT_CNT_W'(1);
    end
    // Hardware clear wins over a host set in the same cycle
    if (st_next.opt[CHGOPT_B_AUTO_OFF] && !bat_pin_s)
      st_next.opt[CHGOPT_B_ILIM_EN] = 1'b0; // RL4
    st_next.rd = chgopt_read(rd_addr, st_next.opt, st_next.ichg);
    st_next.adapter_ok = adapter_valid ||
      (st_next.opt[CHGOPT_B_SRC_OK] && src_mode_s); // RL5
  end

  // Single state register; everything resets to documented defaults
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.opt <= CHGOPT_RESET;
      st_reg.ichg <= CHGOPT_ICHG_RESET;
    end
    else
      st_reg <= st_next;
  end

  // Block enables; low-power applies only with battery alone
  always_comb
  begin
    logic lp;
    lp = st_reg.opt[CHGOPT_B_LOW_POWER] && !adp_present_s; // RL6 RL8
    internal_regulator_output = !lp; // RL6
    hot_alert_enable = !lp || hot_alert_lowpower_enable; // RL6 RL7
    monitor_enable = !lp; // RL6
    comparator_enable = !lp || hot_alert_lowpower_enable; // RL7
    adc_available = !lp; // RL6
  end

  assign rd_data = st_reg.rd;
  assign adapter_good_output = st_reg.adapter_ok;
  assign audible_band_avoid = st_reg.opt[CHGOPT_B_AUDIBLE]; // RL9
  assign switching_rate_select = st_reg.opt[CHGOPT_B_RATE]; // RL10
  assign weak_gate_drive_select = st_reg.opt[CHGOPT_B_WEAK_GD]; // RL11
  assign input_limit_loop_enable = st_reg.opt[CHGOPT_B_ILIM_EN];
  assign charge_current = st_reg.ichg;
  assign watchdog_expired = st_reg.expired;
endmodule : chgopt_ctrl

//--- verilog/chgopt_pkg.sv
// Constants for the charger option control register and its watchdog.
// Assumes a 100 MHz system clock and byte-wide host writes over I2C.
package chgopt_pkg;
  localparam int CHGOPT_CLK_HZ = 100_000_000;
  localparam logic [7:0] CHGOPT_OFS_LSB = 8'h00;
  localparam logic [7:0] CHGOPT_OFS_MSB = 8'h01;
  localparam logic [7:0] CHGOPT_OFS_ICHG_LSB = 8'h02;
  localparam logic [7:0] CHGOPT_OFS_ICHG_MSB = 8'h03;
  localparam logic [7:0] CHGOPT_OFS_VCHG_LSB = 8'h04;
  localparam logic [7:0] CHGOPT_OFS_VCHG_MSB = 8'h05;
  localparam logic [15:0] CHGOPT_RESET = 16'hE70E;
  localparam logic [15:0] CHGOPT_ICHG_RESET = 16'h0000;
  // Field positions inside the sixteen-bit register
  localparam int CHGOPT_B_LOW_POWER = 15;
  localparam int CHGOPT_B_WDT_HI = 14;
  localparam int CHGOPT_B_WDT_LO = 13;
  localparam int CHGOPT_B_AUTO_OFF = 12;
  localparam int CHGOPT_B_SRC_OK = 11;
  localparam int CHGOPT_B_AUDIBLE = 10;
  localparam int CHGOPT_B_RATE = 9;
  localparam int CHGOPT_B_WEAK_GD = 8;
  localparam int CHGOPT_B_ILIM_EN = 1;
  localparam logic [1:0] CHGOPT_WDT_OFF = 2'h0;
  localparam logic [1:0] CHGOPT_WDT_5S = 2'h1;
  localparam logic [1:0] CHGOPT_WDT_88S = 2'h2;
  localparam logic [1:0] CHGOPT_WDT_175S = 2'h3;
  localparam int CHGOPT_WDT_5S_SEC = 5;
  localparam int CHGOPT_WDT_88S_SEC = 88;
  localparam int CHGOPT_WDT_175S_SEC = 175;
  localparam longint CHGOPT_WDT_5S_CYC =
    longint'(CHGOPT_WDT_5S_SEC) * longint'(CHGOPT_CLK_HZ);
  localparam longint CHGOPT_WDT_88S_CYC =
    longint'(CHGOPT_WDT_88S_SEC) * longint'(CHGOPT_CLK_HZ);
  localparam longint CHGOPT_WDT_175S_CYC =
    longint'(CHGOPT_WDT_175S_SEC) * longint'(CHGOPT_CLK_HZ);
  localparam int CHGOPT_CNT_W = 35;
  localparam int CHGOPT_OOA_KHZ = 25;
  localparam int CHGOPT_RATE_FAST_KHZ = 1200;
  localparam int CHGOPT_RATE_SLOW_KHZ = 800;
  localparam logic CHGOPT_RATE_FAST = 1'b0;
  localparam logic CHGOPT_RATE_SLOW = 1'b1;
endpackage : chgopt_pkg

//--- verilog/chgopt_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the destination clock is clk_sys; first stage is read only here.
`timescale 1ns/1ps
module chgopt_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Second flop only reads the first; metastability settles in between
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : chgopt_sync

//--- tb/chgopt_assertions.sv
// Port checker for the charger option block.
// Assumes a bind from the bench and shortened watchdog counts.
`timescale 1ns/1ps
module chgopt_ctrl_chk
  import chgopt_pkg::*;
#(
  parameter longint WDT_5S_CYC = 50,
  parameter longint WDT_88S_CYC = 80,
  parameter longint WDT_175S_CYC = 100
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_stb,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic battery_present_cell_pin,
  input wire logic adapter_present,
  input wire logic source_mode_active,
  input wire logic adapter_valid,
  input wire logic hot_alert_lowpower_enable,
  input wire logic adapter_good_output,
  input wire logic internal_regulator_output,
  input wire logic hot_alert_enable,
  input wire logic monitor_enable,
  input wire logic comparator_enable,
  input wire logic adc_available,
  input wire logic audible_band_avoid,
  input wire logic switching_rate_select,
  input wire logic weak_gate_drive_select,
  input wire logic input_limit_loop_enable,
  input wire logic [15:0] charge_current,
  input wire logic watchdog_expired
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Byte strobes decoded once; a lone high byte never moves the fields
  wire lsb = wr_stb && wr_addr == CHGOPT_OFS_LSB;
  wire msb = wr_stb && wr_addr == CHGOPT_OFS_MSB;
  pair_apply_a: assert property (
    msb && $past(lsb) && !watchdog_expired |=> {audible_band_avoid,
    switching_rate_select, weak_gate_drive_select} == $past(wr_data[2:0]))
    else $error("option pair not applied");
  msb_first_a: assert property (msb && $past(msb) |=> $stable(
    {audible_band_avoid, switching_rate_select, weak_gate_drive_select}))
    else $error("lone high byte applied");
  wdt_zero_a: assert property (
    watchdog_expired |-> charge_current == 16'h0000)
    else $error("current not zero after expiry");
  adapter_on_a: assert property (adapter_present[*3] |=>
    internal_regulator_output && monitor_enable && adc_available)
    else $error("blocks gated with adapter present");
  cmp_follow_a: assert property (comparator_enable ==
    (internal_regulator_output || hot_alert_lowpower_enable))
    else $error("comparator enable wrong");
  lp_hot_a: assert property (hot_alert_lowpower_enable |->
    hot_alert_enable && comparator_enable)
    else $error("hot alert off in low power");
  good_on_a: assert property (adapter_valid |=> adapter_good_output)
    else $error("adapter good missing");
  good_off_a: assert property (
    (!adapter_valid && !source_mode_active)[*4] |=> !adapter_good_output)
    else $error("adapter good stuck high");
endmodule : chgopt_ctrl_chk

//--- tb/chgopt_host_model.sv
// Host side model issuing byte writes to the option block.
// Assumes clk_sys; drives just after rising edges only.
`timescale 1ns/1ps
module chgopt_host_model (
  input wire logic clk_sys,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);
  initial
  begin
    wr_stb = 1'b0;
    wr_addr = 8'hA5;
    wr_data = 8'h5A;
  end
  // Low byte then high byte on back-to-back edges; n=1 sends one byte
  task automatic send(logic [7:0] ofs, logic [15:0] v, int n = 2);
    @(posedge clk_sys);
    #1;
    wr_stb = 1'b1;
    wr_addr = ofs;
    wr_data = v[7:0];
    if (n == 2)
    begin
      @(posedge clk_sys);
      #1;
      wr_addr = ofs + 8'h01;
      wr_data = v[15:8];
    end
    @(posedge clk_sys);
    #1;
    // Released lines carry garbage so stale data is never mistaken
    wr_stb = 1'b0;
    wr_addr = ~wr_addr;
    wr_data = ~wr_data;
  endtask : send
endmodule : chgopt_host_model

//--- tb/test_charger_option_control_reg.sv
// Self-checking bench for the charger option block.
// Assumes short watchdog counts of 50, 80 and 100 cycles.
`timescale 1ns/1ps
module test_charger_option_control_reg;
  import chgopt_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wr_stb;
  logic [7:0] wr_addr, wr_data, rd_data;
  logic [7:0] rd_addr = 8'h00;
  logic battery_present_cell_pin = 1'b1;
  logic adapter_present = 1'b0;
  logic source_mode_active = 1'b0;
  logic adapter_valid = 1'b0;
  logic hot_alert_lowpower_enable = 1'b0;
  logic adapter_good_output, internal_regulator_output, hot_alert_enable;
  logic monitor_enable, comparator_enable, adc_available, audible_band_avoid;
  logic switching_rate_select, weak_gate_drive_select, input_limit_loop_enable;
  logic [15:0] charge_current, v;
  logic watchdog_expired;
  int miscompares = 0;
  int check_count = 0;
  chgopt_ctrl #(.WDT_5S_CYC(50), .WDT_88S_CYC(80), .WDT_175S_CYC(100)) dut (.*);
  chgopt_host_model host (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Registered read port: address now, byte one edge later
  task automatic rd16(logic [7:0] ofs);
    rd_addr = ofs;
    cyc(1);
    v[7:0] = rd_data;
    rd_addr = ofs + 8'h01;
    cyc(1);
    v[15:8] = rd_data;
  endtask : rd16
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic t_order;
    rd16(CHGOPT_OFS_LSB);
    chk("reset", CHGOPT_RESET, v);
    chk("rate", CHGOPT_RATE_SLOW, switching_rate_select);
    host.send(CHGOPT_OFS_MSB, 16'h0000, 1);
    rd16(CHGOPT_OFS_LSB);
    chk("lone msb", CHGOPT_RESET, v);
    host.send(CHGOPT_OFS_LSB, 16'h000E);
    cyc(1);
    chk("rate", CHGOPT_RATE_FAST, switching_rate_select);
    chk("gate", 0, weak_gate_drive_select);
    chk("ooa", 0, audible_band_avoid);
    $display("order test done");
  endtask : t_order
  task automatic t_wdt;
    host.send(CHGOPT_OFS_LSB, 16'h200E);
    host.send(CHGOPT_OFS_ICHG_LSB, 16'h0140);
    cyc(30);
    host.send(CHGOPT_OFS_ICHG_LSB, 16'h0180);
    cyc(30);
    chk("cur", 16'h0180, charge_current);
    cyc(25);
    chk("exp", 1, watchdog_expired);
    chk("cur", 0, charge_current);
    host.send(CHGOPT_OFS_LSB, 16'h400E);
    cyc(70);
    chk("exp", 0, watchdog_expired);
    cyc(15);
    chk("exp", 1, watchdog_expired);
    host.send(CHGOPT_OFS_LSB, 16'h000E);
    cyc(120);
    chk("exp", 0, watchdog_expired);
    // A low byte left pending past the period must not pair later
    host.send(CHGOPT_OFS_LSB, 16'h200E);
    host.send(CHGOPT_OFS_ICHG_LSB, 16'h0040, 1);
    cyc(60);
    host.send(CHGOPT_OFS_ICHG_MSB, 16'h0002, 1);
    cyc(1);
    chk("late", 16'h0000, charge_current);
    chk("exp", 1, watchdog_expired);
    $display("watchdog test done");
  endtask : t_wdt
  task automatic t_pins;
    host.send(CHGOPT_OFS_LSB, 16'h180E);
    battery_present_cell_pin = 1'b0;
    source_mode_active = 1'b1;
    cyc(6);
    chk("ilim", 0, input_limit_loop_enable);
    chk("good", 1, adapter_good_output);
    battery_present_cell_pin = 1'b1;
    cyc(3);
    host.send(CHGOPT_OFS_LSB, 16'h800E);
    cyc(1);
    chk("ilim", 1, input_limit_loop_enable);
    chk("good", 0, adapter_good_output);
    chk("internal_regulator_output", 0, internal_regulator_output);
    chk("adc", 0, adc_available);
    chk("cmp", 0, comparator_enable);
    chk("mon", 0, monitor_enable);
    chk("hot", 0, hot_alert_enable);
    hot_alert_lowpower_enable = 1'b1;
    cyc(1);
    chk("cmp", 1, comparator_enable);
    chk("hot", 1, hot_alert_enable);
    // Adapter arrival lifts low-power gating after the pin sync
    hot_alert_lowpower_enable = 1'b0;
    adapter_present = 1'b1;
    cyc(3);
    chk("internal_regulator_output", 1, internal_regulator_output);
    chk("mon", 1, monitor_enable);
    $display("pin test done");
  endtask : t_pins
  // Main sequence; a stray hang is cut by the limit below
  initial
  begin
    cyc(4);
    arst_n = 1'b1;
    cyc(1);
    t_order;
    t_wdt;
    t_pins;
    tally_and_finish;
  end
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
endmodule : test_charger_option_control_reg
bind chgopt_ctrl chgopt_ctrl_chk #(.WDT_5S_CYC(WDT_5S_CYC),
  .WDT_88S_CYC(WDT_88S_CYC), .WDT_175S_CYC(WDT_175S_CYC)) chk (.*);
